// ==== mqf_consts.svh ====
/*
  Constants of the multi-queue active flag block: register offsets, field
  positions, reset values, queue geometry and flag latencies.
  Assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef MQF_CONSTS_SVH
`define MQF_CONSTS_SVH

// queue geometry, per device
`define QUEUE_COUNT 32
`define QUEUE_DEPTH 10'h200
`define DEF_OFFSET_LO 10'h008
`define DEF_OFFSET_HI 10'h080

// register byte offsets
`define REG_CTRL 12'h000
`define REG_OFFS_SEL 12'h004
`define REG_AF_OFFSET 12'h008
`define REG_AE_OFFSET 12'h00C
`define REG_STATUS 12'h010

// control field positions
`define CTRL_DEFPROG_BIT 0
`define CTRL_DEFSEL_BIT 1
`define CTRL_IDW_LSB 2
`define CTRL_WORD_LSB 4

// status field positions
`define STAT_EF_BIT 0
`define STAT_AF_BIT 1
`define STAT_AE_BIT 2
`define STAT_DRIVE_BIT 3
`define STAT_LEVEL_LSB 16

// reset values
`define CTRL_RESET 6'h0D
`define OFFSET_RESET 10'h000
`define LEVEL_RESET 10'h000

// rising edges from a queue selection to the flag showing the new queue
`define SEL_LAT_CYC 3
// rising edges from a level change to the flag following it
`define FLAG_LAT_CYC 2

`endif

// ==== mqf_pkg.sv ====
/*
  Types of the multi-queue active flag block.
  Assumes mqf_consts.svh is on the include path.
*/
package mqf_pkg;

  typedef logic [4:0] qidx_t;
  typedef logic [9:0] level_t;

  // control register; id_width 1..3 selects how many address msbs name the device
  typedef struct packed {
    logic [1:0] word_sel;
    logic [1:0] id_width;
    logic def_sel;
    logic def_prog;
  } ctrl_s;

  // one stage of the active flag pipeline, all bits active high
  typedef struct packed {
    logic empty;
    logic almost_full;
    logic almost_empty;
    logic drive;
  } flag_s;

endpackage

// ==== multiqueue_active_flag_logic.sv ====
/*
  Active queue flag logic of a 32-queue flow-control device: queue levels,
  per-queue offsets, active empty / almost-full / almost-empty flags with the
  expansion drive control, and eight-bit flag status copies. APB slave.
  Assumes write and read ports come from logic on pclk; the id pins are
  static straps from the board and are synchronised.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
// Summary of operation
// - empty flag released when no own queue read
// - read address msbs against id pins drive flag
// - id one to three bits, 256 queues total
// - same device keeps driving, flag follows switch
// - almost-full shows the selected write queue
// - every queue keeps almost-full, reads change it
// - per-queue almost-full offset zero to depth
// - default offsets 8 or 128 otherwise programmed
// - almost-full shows new queue third edge after
// - almost-full double registered, low two cycles
// - almost-full rises after read, skew cycle
// - almost-full changes only on rising edges
// - eight-bit bus copies of both statuses
// - almost-empty shows the selected read queue
// - per-queue almost-empty offset zero to depth
// - almost-empty shows new queue third edge after
// - almost-empty double registered, low two cycles
// - almost-empty rises after write, skew cycle
// - every queue keeps almost-empty, writes change it
`timescale 1ns/1ps
`include "mqf_consts.svh"

module multiqueue_active_flag_logic (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // write port
  input wire logic [7:0] write_queue_addr,
  input wire logic write_addr_enable,
  input wire logic write_en,
  // read port
  input wire logic [7:0] read_queue_addr,
  input wire logic read_addr_enable,
  input wire logic read_en,
  // device identity straps
  input wire logic device_id_bit0,
  input wire logic device_id_bit1,
  input wire logic device_id_bit2,
  // active queue flags
  output logic empty_flag_n,
  output logic empty_flag_oe_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  // flag status buses
  output logic [7:0] af_bus_n,
  output logic [7:0] ae_bus_n
);

  localparam int QN = `QUEUE_COUNT;

  // effective offset: default value or the programmed one
  function automatic mqf_pkg::level_t eff_off(input logic prog, input logic sel,
                                             input mqf_pkg::level_t off);
    if (prog) begin
      eff_off = sel ? `DEF_OFFSET_HI : `DEF_OFFSET_LO;
    end else begin
      eff_off = off;
    end
  endfunction

  // device match on the address msbs, width 1..3 (0 acts as 3)
  function automatic logic id_hit(input logic [2:0] hi, input logic [2:0] id,
                                  input logic [1:0] width);
    if (width == 2'h1) begin
      id_hit = (hi[2] == id[0]);
    end else if (width == 2'h2) begin
      id_hit = (hi[2:1] == id[1:0]);
    end else begin
      id_hit = (hi == id);
    end
  endfunction

  // offsets above the queue depth are clamped to it
  function automatic mqf_pkg::level_t clamp_off(input logic [31:0] d);
    if (d[31:10] != 22'h00_0000 || d[9:0] > `QUEUE_DEPTH) begin
      clamp_off = `QUEUE_DEPTH;
    end else begin
      clamp_off = d[9:0];
    end
  endfunction

  mqf_pkg::ctrl_s ctrl_ff;
  mqf_pkg::qidx_t offs_sel_ff;
  mqf_pkg::level_t af_off_ff [QN];
  mqf_pkg::level_t ae_off_ff [QN];
  mqf_pkg::level_t level_ff [QN];
  logic [2:0] id_meta_ff;
  logic [2:0] id_sync_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  mqf_pkg::qidx_t wq_addr_ff;
  mqf_pkg::qidx_t wq_act_ff;
  logic [7:0] rq_addr_ff;
  mqf_pkg::qidx_t rq_act_ff;
  logic rd_match_ff;
  mqf_pkg::flag_s s1_ff;
  mqf_pkg::flag_s out_ff;
  logic [7:0] af_bus_ff;
  logic [7:0] ae_bus_ff;
  logic [QN-1:0] af_vec;
  logic [QN-1:0] ae_vec;
  logic [QN-1:0] em_vec;
  logic af_sel_now;
  logic ae_sel_now;
  logic em_sel_now;
  logic wr_acc;
  logic setup;
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;

  // static id straps pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_meta_ff <= 3'h0;
      id_sync_ff <= 3'h0;
    end else begin
      id_meta_ff <= {device_id_bit2, device_id_bit1, device_id_bit0};
      id_sync_ff <= id_meta_ff;
    end
  end

  // control and offset programming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= mqf_pkg::ctrl_s'(`CTRL_RESET);
      offs_sel_ff <= 5'h00;
    end else if (wr_acc && paddr == `REG_CTRL) begin
      ctrl_ff <= mqf_pkg::ctrl_s'(pwdata[5:0]);
    end else if (wr_acc && paddr == `REG_OFFS_SEL) begin
      offs_sel_ff <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < QN; i++) begin
        af_off_ff[i] <= `OFFSET_RESET;
        ae_off_ff[i] <= `OFFSET_RESET;
      end
    end else if (wr_acc && paddr == `REG_AF_OFFSET) begin
      af_off_ff[offs_sel_ff] <= clamp_off(pwdata);
    end else if (wr_acc && paddr == `REG_AE_OFFSET) begin
      ae_off_ff[offs_sel_ff] <= clamp_off(pwdata);
    end
  end

  // queue selection pipeline; selection edge, then active, then flag stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wq_addr_ff <= 5'h00;
      wq_act_ff <= 5'h00;
    end else begin
      if (write_addr_enable) begin
        wq_addr_ff <= write_queue_addr[4:0];
      end
      wq_act_ff <= wq_addr_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rq_addr_ff <= 8'h00;
      rq_act_ff <= 5'h00;
      rd_match_ff <= 1'b0;
    end else begin
      if (read_addr_enable) begin
        rq_addr_ff <= read_queue_addr;
      end
      rq_act_ff <= rq_addr_ff[4:0];
      rd_match_ff <= id_hit(rq_addr_ff[7:5], id_sync_ff, ctrl_ff.id_width);
    end
  end

  // per-queue levels; a write and a read of one queue cancel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < QN; i++) begin
        level_ff[i] <= `LEVEL_RESET;
      end
    end else begin
      for (int i = 0; i < QN; i++) begin
        if (write_en && wq_act_ff == 5'(i) && !(read_en && rq_act_ff == 5'(i))) begin
          if (level_ff[i] != `QUEUE_DEPTH) begin
            level_ff[i] <= level_ff[i] + 10'h001;
          end
        end else if (read_en && rq_act_ff == 5'(i) && !(write_en && wq_act_ff == 5'(i))) begin
          if (level_ff[i] != `LEVEL_RESET) begin
            level_ff[i] <= level_ff[i] - 10'h001;
          end
        end
      end
    end
  end

  // status of every queue, whether selected or not
  always_comb begin
    for (int i = 0; i < QN; i++) begin
      af_vec[i] = level_ff[i] >=
                  (`QUEUE_DEPTH - eff_off(ctrl_ff.def_prog, ctrl_ff.def_sel, af_off_ff[i]));
      ae_vec[i] = level_ff[i] <=
                  eff_off(ctrl_ff.def_prog, ctrl_ff.def_sel, ae_off_ff[i]);
      em_vec[i] = (level_ff[i] == `LEVEL_RESET);
    end
  end

  assign af_sel_now = af_vec[wq_act_ff];
  assign ae_sel_now = ae_vec[rq_act_ff];
  assign em_sel_now = em_vec[rq_act_ff];

  // two flag stages; all flag changes on the rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff.empty <= em_sel_now;
      s1_ff.almost_full <= af_sel_now;
      s1_ff.almost_empty <= ae_sel_now;
      s1_ff.drive <= rd_match_ff;
      out_ff <= s1_ff;
    end
  end

  // status word copies on the flag buses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_bus_ff <= 8'hFF;
      ae_bus_ff <= 8'hFF;
    end else begin
      af_bus_ff <= ~af_vec[{ctrl_ff.word_sel, 3'h0} +: 8];
      ae_bus_ff <= ~ae_vec[{ctrl_ff.word_sel, 3'h0} +: 8];
    end
  end

  assign empty_flag_n = !out_ff.empty;
  assign empty_flag_oe_n = !out_ff.drive;
  assign almost_full_flag_n = !out_ff.almost_full;
  assign almost_empty_flag_n = !out_ff.almost_empty;
  assign af_bus_n = af_bus_ff;
  assign ae_bus_n = ae_bus_ff;

  // read data and error are prepared in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (paddr == `REG_CTRL) begin
      nxt_prdata[5:0] = ctrl_ff;
    end else if (paddr == `REG_OFFS_SEL) begin
      nxt_prdata[4:0] = offs_sel_ff;
    end else if (paddr == `REG_AF_OFFSET) begin
      nxt_prdata[9:0] = af_off_ff[offs_sel_ff];
    end else if (paddr == `REG_AE_OFFSET) begin
      nxt_prdata[9:0] = ae_off_ff[offs_sel_ff];
    end else if (paddr == `REG_STATUS) begin
      nxt_prdata[`STAT_EF_BIT] = empty_flag_n;
      nxt_prdata[`STAT_AF_BIT] = almost_full_flag_n;
      nxt_prdata[`STAT_AE_BIT] = almost_empty_flag_n;
      nxt_prdata[`STAT_DRIVE_BIT] = out_ff.drive;
      nxt_prdata[`STAT_LEVEL_LSB +: 10] = level_ff[offs_sel_ff];
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && pslverr_ff;

  // checks
  ef_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_addr_enable ##1 (!read_addr_enable)[*2] |=> ##1
      empty_flag_oe_n == !id_hit($past(read_queue_addr[7:5], 4), id_sync_ff,
                                 ctrl_ff.id_width))
    else $error("empty flag drive does not follow device match");

  ef_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> empty_flag_oe_n == !$past(rd_match_ff, 2))
    else $error("empty flag enable not two edges after match");

  ef_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    !empty_flag_oe_n |-> empty_flag_n == !$past(em_sel_now, 2))
    else $error("driven empty flag does not show active queue");

  af_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    write_addr_enable |-> ##2 wq_act_ff == $past(write_queue_addr[4:0], 2))
    else $error("write queue switch not active on second edge");

  af_pipe_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> almost_full_flag_n == !$past(af_sel_now, 2))
    else $error("almost full flag not two edges behind status");

  af_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(af_sel_now) && !af_sel_now && $stable(wq_act_ff)) |-> ##2 almost_full_flag_n)
    else $error("almost full flag did not rise after clear");

  ae_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    read_addr_enable |-> ##2 rq_act_ff == $past(read_queue_addr[4:0], 2))
    else $error("read queue switch not active on second edge");

  ae_pipe_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> almost_empty_flag_n == !$past(ae_sel_now, 2))
    else $error("almost empty flag not two edges behind status");

  ae_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(ae_sel_now) && !ae_sel_now && $stable(rq_act_ff)) |-> ##2 almost_empty_flag_n)
    else $error("almost empty flag did not rise after clear");

  offset_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    af_off_ff[offs_sel_ff] <= `QUEUE_DEPTH && ae_off_ff[offs_sel_ff] <= `QUEUE_DEPTH)
    else $error("programmed offset beyond queue depth");

  bus_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(ctrl_ff.word_sel) |=> af_bus_n == ~$past(af_vec[{ctrl_ff.word_sel, 3'h0} +: 8]))
    else $error("almost full bus is not a copy of status");

endmodule // multiqueue_active_flag_logic

// ==== queue_ctrl_model.sv ====
/*
  System controller model: drives the queue write and read ports.
  Assumes the bench calls its tasks from one sequence on pclk.
*/
`timescale 1ns/1ps
module queue_ctrl_model (
  // clock
  input wire logic pclk,
  // write port
  output logic [7:0] write_queue_addr,
  output logic write_addr_enable,
  output logic write_en,
  // read port
  output logic [7:0] read_queue_addr,
  output logic read_addr_enable,
  output logic read_en
);
  initial begin
    write_queue_addr = 8'h00;
    write_addr_enable = 1'b0;
    write_en = 1'b0;
    read_queue_addr = 8'h00;
    read_addr_enable = 1'b0;
    read_en = 1'b0;
  end

  // top bits name the one device read at a time
  task sel_rd(input logic [7:0] a);
    @(posedge pclk);
    read_queue_addr <= a;
    read_addr_enable <= 1'b1;
    @(posedge pclk);
    read_addr_enable <= 1'b0;
  endtask

  task sel_wr(input logic [7:0] a);
    @(posedge pclk);
    write_queue_addr <= a;
    write_addr_enable <= 1'b1;
    @(posedge pclk);
    write_addr_enable <= 1'b0;
  endtask

  task xfer(input logic w, input logic r, input int n);
    repeat (n) begin
      @(posedge pclk);
      write_en <= w;
      read_en <= r;
    end
    @(posedge pclk);
    write_en <= 1'b0;
    read_en <= 1'b0;
  endtask
endmodule // queue_ctrl_model

// ==== testbench.sv ====
/*
  Testbench of the active flag block: apb master, controller model, flag checks.
  Assumes package, constants header and controller model are compiled first.
*/
`timescale 1ns/1ps
`include "mqf_consts.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] waddr, raddr, afb, aeb;
  logic waen, wen, raen, ren, ef_n, oe_n, af_n, ae_n;
  logic [2:0] id = 3'h0;
  logic [4:0] qa, qb;
  logic [31:0] seed = 32'haa05_c364;
  int fail_count = 0;
  int compares = 0;

  always #12.5 pclk = ~pclk;

  queue_ctrl_model ctl (.pclk(pclk), .write_queue_addr(waddr), .write_addr_enable(waen),
    .write_en(wen), .read_queue_addr(raddr), .read_addr_enable(raen), .read_en(ren));

  multiqueue_active_flag_logic uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .write_queue_addr(waddr), .write_addr_enable(waen),
    .write_en(wen), .read_queue_addr(raddr), .read_addr_enable(raen), .read_en(ren),
    .device_id_bit0(id[0]), .device_id_bit1(id[1]), .device_id_bit2(id[2]),
    .empty_flag_n(ef_n), .empty_flag_oe_n(oe_n), .almost_full_flag_n(af_n),
    .almost_empty_flag_n(ae_n), .af_bus_n(afb), .ae_bus_n(aeb));

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // active low: high while the boundary is not reached
  function logic af_exp(input int lv, input int off);
    return lv < `QUEUE_DEPTH - off;
  endfunction

  function logic ae_exp(input int lv, input int off);
    return lv > off;
  endfunction

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    $display("ERROR watchdog expected end seen hang");
    give_verdict;
  end

  initial begin
    seed = lfsr(seed);
    id = seed[2:0];
    qa = seed[12:8];
    qb = qa ^ 5'h01;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle(3);
    chk("ae_n", ae_exp(0, 8), ae_n);
    chk("af_n", af_exp(0, 8), af_n);
    chk("ae_bus", 8'h00, aeb);
    chk("af_bus", 8'hff, afb);
    apb(1'b0, `REG_CTRL, 32'h0000_0000);
    chk("ctrl", `CTRL_RESET, rd);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("slverr", 1'b1, err);
    $display("reset test done");
    ctl.sel_rd({id, qa});
    settle(3);
    chk("oe_n", 1'b0, oe_n);
    chk("ef_n", 1'b0, ef_n);
    ctl.sel_rd({~id, qa});
    settle(2);
    chk("oe_n", 1'b0, oe_n);
    settle(1);
    chk("oe_n", 1'b1, oe_n);
    ctl.sel_rd({id, qa});
    ctl.sel_wr({3'h0, qa});
    ctl.xfer(1'b1, 1'b0, 9);
    settle(1);
    chk("ae_n", ae_exp(8, 8), ae_n);
    settle(1);
    chk("ae_n", ae_exp(9, 8), ae_n);
    chk("ef_n", 1'b1, ef_n);
    ctl.xfer(1'b0, 1'b1, 1);
    settle(1);
    chk("ae_n", ae_exp(9, 8), ae_n);
    settle(1);
    chk("ae_n", ae_exp(8, 8), ae_n);
    $display("almost empty test done");
    ctl.xfer(1'b1, 1'b0, 495);
    ctl.xfer(1'b1, 1'b0, 1);
    settle(1);
    chk("af_n", af_exp(503, 8), af_n);
    settle(1);
    chk("af_n", af_exp(504, 8), af_n);
    ctl.sel_wr({3'h0, qb});
    settle(2);
    chk("af_n", af_exp(504, 8), af_n);
    settle(1);
    chk("af_n", af_exp(0, 8), af_n);
    ctl.sel_rd({id, qb});
    settle(3);
    chk("oe_n", 1'b0, oe_n);
    chk("ef_n", 1'b0, ef_n);
    ctl.sel_rd({id, qa});
    ctl.xfer(1'b0, 1'b1, 1);
    ctl.sel_wr({3'h0, qa});
    settle(3);
    chk("af_n", af_exp(503, 8), af_n);
    ctl.xfer(1'b1, 1'b0, 1);
    settle(2);
    ctl.xfer(1'b0, 1'b1, 1);
    settle(1);
    chk("af_n", af_exp(504, 8), af_n);
    settle(1);
    chk("af_n", af_exp(503, 8), af_n);
    $display("almost full test done");
    apb(1'b1, `REG_CTRL, 32'h0000_000f);
    settle(3);
    chk("af_n", af_exp(503, 128), af_n);
    apb(1'b1, `REG_OFFS_SEL, {27'h000_0000, qa});
    apb(1'b1, `REG_CTRL, 32'h0000_000c);
    settle(3);
    chk("af_n", af_exp(503, 0), af_n);
    apb(1'b1, `REG_AE_OFFSET, 32'h0000_0258);
    settle(3);
    chk("ae_n", ae_exp(503, 512), ae_n);
    // programmed almost-full offset, one-bit id match, status word of queue qa
    apb(1'b1, `REG_AF_OFFSET, 32'h0000_0010);
    apb(1'b1, `REG_CTRL, {26'h000_0000, qa[4:3], 4'h4});
    ctl.sel_rd({id[0], ~id[1:0], qa});
    settle(3);
    chk("af_n", af_exp(503, 16), af_n);
    chk("oe_n", 1'b0, oe_n);
    chk("af_bus", 8'(~(8'h01 << qa[2:0])), afb);
    chk("ae_bus", 8'h00, aeb);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("level", 32'h0000_01f7, {22'h00_0000, rd[25:16]});
    $display("offset test done");
    give_verdict;
  end
endmodule // testbench
